// ===== hdl/rcc_pkg.sv
package rcc_pkg;

    // Clock and power-system timing.
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned NOM_FREQ_HZ = 60;
    localparam int unsigned TICKS_PER_CYCLE = 4;
    localparam int unsigned TICK_SHIFT = 2;
    localparam int unsigned TICK_CLKS =
        CLK_HZ / (NOM_FREQ_HZ * TICKS_PER_CYCLE);

    // Register port, setting and counter widths.
    localparam int unsigned AW = 3;
    localparam int unsigned DW = 16;
    localparam int unsigned CYC_W = 16;
    localparam int unsigned CNT_W = CYC_W + TICK_SHIFT;
    localparam int unsigned SHOT_W = 2;

    // Register offsets (word index on the plain register port).
    localparam logic [AW-1:0] REG_CTRL = 3'h0;
    localparam logic [AW-1:0] REG_STATE = 3'h1;
    localparam logic [AW-1:0] REG_IRQ_STAT = 3'h2;
    localparam logic [AW-1:0] REG_IRQ_MASK = 3'h3;
    localparam logic [AW-1:0] REG_LO_RESET = 3'h4;
    localparam logic [AW-1:0] REG_MIN_TRIP = 3'h5;
    localparam logic [AW-1:0] REG_OPEN_INT1 = 3'h6;
    localparam logic [AW-1:0] REG_TOC_DELAY = 3'h7;

    // Setting reset values, all in power-system cycles.
    localparam logic [CYC_W-1:0] LO_RESET_RST = 16'h012c;
    localparam logic [CYC_W-1:0] MIN_TRIP_RST = 16'h0009;
    localparam logic [CYC_W-1:0] OPEN_INT1_RST = 16'h001e;
    localparam logic [CYC_W-1:0] TOC_DELAY_RST = 16'h003c;

    // Control register fields.
    localparam int unsigned CTRL_MANUAL_CLOSE = 0;

    // State register fields.
    localparam int unsigned F_TRIP = 0;
    localparam int unsigned F_CLOSE = 1;
    localparam int unsigned F_LOCKOUT = 2;
    localparam int unsigned F_CYCLE = 3;
    localparam int unsigned F_BREAKER = 4;
    localparam int unsigned F_ENABLE = 5;
    localparam int unsigned F_SHOT = 6;
    localparam int unsigned F_PH_PU = 8;
    localparam int unsigned F_RES_PU = 9;
    localparam int unsigned F_PH_TOC = 10;
    localparam int unsigned F_RES_TOC = 11;
    localparam int unsigned F_MANUAL = 12;

    // Interrupt event bits.
    localparam int unsigned EV_W = 5;
    localparam int unsigned EV_TRIP = 0;
    localparam int unsigned EV_RECLOSE = 1;
    localparam int unsigned EV_LOCKOUT = 2;
    localparam int unsigned EV_LO_EXIT = 3;
    localparam int unsigned EV_TOC = 4;

    // Reclosing states, Gray coded along reset, cycle, lockout.
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_CYCLE = 2'h1,
        ST_LOCKOUT = 2'h3
    } rcc_state_t;

    // Field-side inputs, all asynchronous to sys_clk_i.
    typedef struct packed {
        logic reclose_enable_input;
        logic breaker_status_input;
        logic phase_instant_overcurrent;
        logic phase_fault;
        logic residual_fault;
    } rcc_pins_t;

    // Register port request.
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } rcc_bus_t;

endpackage

// ===== hdl/rcc_reclose_ctrl.sv
// Behaviour
// - With the enable input low, drive-to-lockout holds and forces lockout.
// - The manual-close local bit is close initiate and asserts close output.
// - The local bit clears within a quarter cycle; the close stays latched.
// - A closed breaker status input releases the latched close output.
// - Lockout leaves for reset once the breaker stays closed 300 cycles.
// - Both time-overcurrent pickups assert on the tick their timing starts.
// - Instant phase pickup at shot zero trips and, from reset, enters the reclose cycle; in lockout it trips only.
// - A low breaker status input means open, which ends the trip hold.
// - Trip stays asserted for at least the minimum trip time, 9 cycles.
// - The first open interval is stalled until the trip output drops.
// - The close output asserts when the 30-cycle first open interval ends.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module rcc_reclose_ctrl import rcc_pkg::*; #(
    parameter int unsigned TICK_DIV = TICK_CLKS,
    parameter int unsigned MAX_SHOTS = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire rcc_pins_t pins_i,
    input wire rcc_bus_t bus_i,
    output logic [DW-1:0] rdata_o,
    output logic trip_output_contact_o,
    output logic close_output_contact_o,
    output logic phase_toc_pickup_o,
    output logic residual_toc_pickup_o,
    output logic lockout_state_o,
    output logic reclose_cycle_state_o,
    output logic irq_o
);

    localparam int unsigned PIN_W = $bits(rcc_pins_t);
    localparam int unsigned DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
    localparam logic [SHOT_W-1:0] SHOT_MAX = SHOT_W'(MAX_SHOTS);

    // Converts a setting in cycles into quarter-cycle ticks.
    function automatic logic [CNT_W-1:0] cyc2tick(input logic [CYC_W-1:0] c);
        cyc2tick = CNT_W'(c) << TICK_SHIFT;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] sync3;
    logic [PIN_W-1:0] pin_q;
    logic [PIN_W-1:0] next_pin_q;
    rcc_pins_t pin;

    // A bit changes only once the second and third stages agree, so a
    // single metastable sample can never reach the protection logic.
    always_comb begin
        next_pin_q = (pin_q & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_q <= '0;
        end else begin
            sync1 <= pins_i;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_q <= next_pin_q;
        end
    end

    assign pin = rcc_pins_t'(pin_q);

    ////////////////////////////////////////////////////////////////////////
    // Quarter-cycle processing tick

    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] next_div_cnt;
    logic tick;
    logic next_tick;

    // One pulse every quarter power-system cycle drives all timers.
    always_comb begin
        next_tick = (div_cnt == DIV_LAST);
        next_div_cnt = next_tick ? '0 : div_cnt + 1'b1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [CYC_W-1:0] cfg_lo_reset;
    logic [CYC_W-1:0] cfg_min_trip;
    logic [CYC_W-1:0] cfg_open_int1;
    logic [CYC_W-1:0] cfg_toc_delay;
    logic [EV_W-1:0] irq_mask;
    logic [EV_W-1:0] irq_status;
    logic manual_close_local_bit;
    logic [CYC_W-1:0] next_cfg_lo_reset;
    logic [CYC_W-1:0] next_cfg_min_trip;
    logic [CYC_W-1:0] next_cfg_open_int1;
    logic [CYC_W-1:0] next_cfg_toc_delay;
    logic [EV_W-1:0] next_irq_mask;
    logic [EV_W-1:0] next_irq_status;
    logic next_manual_close_local_bit;
    logic [DW-1:0] next_rdata;
    logic next_irq;
    logic [EV_W-1:0] events;
    logic [DW-1:0] state_word;

    // Status bits are write-one-to-clear, and a new event beats the clear.
    always_comb begin
        next_cfg_lo_reset = cfg_lo_reset;
        next_cfg_min_trip = cfg_min_trip;
        next_cfg_open_int1 = cfg_open_int1;
        next_cfg_toc_delay = cfg_toc_delay;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_manual_close_local_bit = manual_close_local_bit;
        next_rdata = '0;
        // The local bit lives exactly until the next tick has seen it.
        if (tick) begin
            next_manual_close_local_bit = 1'b0;
        end
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                REG_CTRL: begin
                    if (bus_i.wdata[CTRL_MANUAL_CLOSE]) begin
                        next_manual_close_local_bit = 1'b1;
                    end
                end
                REG_IRQ_STAT: begin
                    next_irq_status = irq_status & ~bus_i.wdata[EV_W-1:0];
                end
                REG_IRQ_MASK: next_irq_mask = bus_i.wdata[EV_W-1:0];
                REG_LO_RESET: next_cfg_lo_reset = bus_i.wdata;
                REG_MIN_TRIP: next_cfg_min_trip = bus_i.wdata;
                REG_OPEN_INT1: next_cfg_open_int1 = bus_i.wdata;
                REG_TOC_DELAY: next_cfg_toc_delay = bus_i.wdata;
                default: ;
            endcase
        end
        next_irq_status = next_irq_status | events;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                REG_CTRL: next_rdata = DW'(manual_close_local_bit);
                REG_STATE: next_rdata = state_word;
                REG_IRQ_STAT: next_rdata = DW'(irq_status);
                REG_IRQ_MASK: next_rdata = DW'(irq_mask);
                REG_LO_RESET: next_rdata = cfg_lo_reset;
                REG_MIN_TRIP: next_rdata = cfg_min_trip;
                REG_OPEN_INT1: next_rdata = cfg_open_int1;
                REG_TOC_DELAY: next_rdata = cfg_toc_delay;
            endcase
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cfg_lo_reset <= LO_RESET_RST;
            cfg_min_trip <= MIN_TRIP_RST;
            cfg_open_int1 <= OPEN_INT1_RST;
            cfg_toc_delay <= TOC_DELAY_RST;
            irq_mask <= '0;
            irq_status <= '0;
            manual_close_local_bit <= 1'b0;
            rdata_o <= '0;
            irq_o <= 1'b0;
        end else begin
            cfg_lo_reset <= next_cfg_lo_reset;
            cfg_min_trip <= next_cfg_min_trip;
            cfg_open_int1 <= next_cfg_open_int1;
            cfg_toc_delay <= next_cfg_toc_delay;
            irq_mask <= next_irq_mask;
            irq_status <= next_irq_status;
            manual_close_local_bit <= next_manual_close_local_bit;
            rdata_o <= next_rdata;
            irq_o <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time-overcurrent pickup and timing, index 0 phase, 1 residual

    logic [1:0] fault_in;
    logic toc_pickup [2];
    logic toc_timed [2];
    logic [CNT_W-1:0] toc_cnt [2];
    logic [1:0] toc_expire;

    assign fault_in = {pin.residual_fault, pin.phase_fault};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_toc
            logic next_pickup;
            logic next_timed;
            logic [CNT_W-1:0] next_cnt;

            // Pickup and timer both start on the tick that sees fault.
            always_comb begin
                next_pickup = toc_pickup[gi];
                next_timed = toc_timed[gi];
                next_cnt = toc_cnt[gi];
                if (tick) begin
                    next_pickup = fault_in[gi];
                    if (!fault_in[gi]) begin
                        next_cnt = '0;
                        next_timed = 1'b0;
                    end else if (toc_cnt[gi] < cyc2tick(cfg_toc_delay)) begin
                        next_cnt = toc_cnt[gi] + 1'b1;
                    end else begin
                        next_timed = 1'b1;
                    end
                end
                toc_expire[gi] = next_timed & ~toc_timed[gi];
            end

            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    toc_pickup[gi] <= 1'b0;
                    toc_timed[gi] <= 1'b0;
                    toc_cnt[gi] <= '0;
                end else begin
                    toc_pickup[gi] <= next_pickup;
                    toc_timed[gi] <= next_timed;
                    toc_cnt[gi] <= next_cnt;
                end
            end
        end
    endgenerate

    assign phase_toc_pickup_o = toc_pickup[0];
    assign residual_toc_pickup_o = toc_pickup[1];

    ////////////////////////////////////////////////////////////////////////
    // Trip, close and reclosing state machine

    rcc_state_t state;
    rcc_state_t next_state;
    logic [SHOT_W-1:0] shot;
    logic [SHOT_W-1:0] next_shot;
    logic [CNT_W-1:0] trip_cnt;
    logic [CNT_W-1:0] next_trip_cnt;
    logic [CNT_W-1:0] oi_cnt;
    logic [CNT_W-1:0] next_oi_cnt;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] next_rst_cnt;
    logic next_trip;
    logic next_close;
    logic shot_zero;
    logic fault_release_condition;
    logic drive_to_lockout;
    logic breaker_aux_contact;
    logic close_initiate;
    logic reclose_now;
    logic [CNT_W-1:0] trip_held;

    always_comb begin
        shot_zero = (shot == '0);
        fault_release_condition =
            pin.phase_instant_overcurrent & shot_zero;
        drive_to_lockout = ~pin.reclose_enable_input;
        breaker_aux_contact = pin.breaker_status_input;
        close_initiate = manual_close_local_bit;
        trip_held = trip_cnt + 1'b1;
        next_state = state;
        next_shot = shot;
        next_trip = trip_output_contact_o;
        next_close = close_output_contact_o;
        next_trip_cnt = trip_cnt;
        next_oi_cnt = oi_cnt;
        next_rst_cnt = rst_cnt;
        reclose_now = 1'b0;
        if (tick) begin
            // Trip is held while the fault or a closed breaker keeps it up,
            // and never for less than the minimum duration.
            if (fault_release_condition && !trip_output_contact_o) begin
                next_trip = 1'b1;
                next_trip_cnt = '0;
            end else if (trip_output_contact_o) begin
                if (trip_cnt < cyc2tick(cfg_min_trip)) begin
                    next_trip_cnt = trip_held;
                end
                if (trip_held >= cyc2tick(cfg_min_trip) &&
                    !fault_release_condition && !breaker_aux_contact) begin
                    next_trip = 1'b0;
                end
            end
            unique case (state)
                ST_LOCKOUT: begin
                    // Leaving lockout needs reclose enabled and a breaker
                    // that has stayed closed for the whole reset time.
                    if (breaker_aux_contact && !drive_to_lockout &&
                        !trip_output_contact_o) begin
                        next_rst_cnt = rst_cnt + 1'b1;
                        if (next_rst_cnt >= cyc2tick(cfg_lo_reset)) begin
                            next_state = ST_RESET;
                            next_rst_cnt = '0;
                            next_shot = '0;
                        end
                    end else begin
                        next_rst_cnt = '0;
                    end
                end
                ST_RESET: begin
                    next_rst_cnt = '0;
                    next_oi_cnt = '0;
                    if (drive_to_lockout) begin
                        next_state = ST_LOCKOUT;
                    end else if (fault_release_condition) begin
                        next_state = ST_CYCLE;
                    end
                end
                ST_CYCLE: begin
                    if (drive_to_lockout) begin
                        next_state = ST_LOCKOUT;
                        next_oi_cnt = '0;
                    end else if (trip_output_contact_o) begin
                        // Open interval waits while trip is up.
                        next_rst_cnt = '0;
                        if (shot >= SHOT_MAX && fault_release_condition) begin
                            next_state = ST_LOCKOUT;
                        end
                    end else if (shot == '0) begin
                        next_oi_cnt = oi_cnt + 1'b1;
                        if (next_oi_cnt >= cyc2tick(cfg_open_int1)) begin
                            reclose_now = 1'b1;
                            next_oi_cnt = '0;
                            next_shot = shot + 1'b1;
                        end
                    end else if (breaker_aux_contact) begin
                        // The reclose held: reuse the reset time to reclaim.
                        next_rst_cnt = rst_cnt + 1'b1;
                        if (next_rst_cnt >= cyc2tick(cfg_lo_reset)) begin
                            next_state = ST_RESET;
                            next_rst_cnt = '0;
                            next_shot = '0;
                        end
                    end else begin
                        next_rst_cnt = '0;
                    end
                end
                default: begin
                    next_state = ST_LOCKOUT;
                end
            endcase
            // Close latch: trip and a closed breaker both release it.
            if (next_trip || breaker_aux_contact) begin
                next_close = 1'b0;
            end else if (close_initiate || reclose_now) begin
                next_close = 1'b1;
            end
        end
        events = '0;
        events[EV_TRIP] = next_trip & ~trip_output_contact_o;
        events[EV_RECLOSE] = reclose_now;
        events[EV_LOCKOUT] = (next_state == ST_LOCKOUT) &&
                             (state != ST_LOCKOUT);
        events[EV_LO_EXIT] = (next_state != ST_LOCKOUT) &&
                             (state == ST_LOCKOUT);
        events[EV_TOC] = |toc_expire;
    end

    // Power-up sits in lockout until a closed breaker has been proven.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= ST_LOCKOUT;
            shot <= '0;
            trip_cnt <= '0;
            oi_cnt <= '0;
            rst_cnt <= '0;
            trip_output_contact_o <= 1'b0;
            close_output_contact_o <= 1'b0;
            lockout_state_o <= 1'b1;
            reclose_cycle_state_o <= 1'b0;
        end else begin
            state <= next_state;
            shot <= next_shot;
            trip_cnt <= next_trip_cnt;
            oi_cnt <= next_oi_cnt;
            rst_cnt <= next_rst_cnt;
            trip_output_contact_o <= next_trip;
            close_output_contact_o <= next_close;
            lockout_state_o <= (next_state == ST_LOCKOUT);
            reclose_cycle_state_o <= (next_state == ST_CYCLE);
        end
    end

    // Live state for software.
    always_comb begin
        state_word = '0;
        state_word[F_TRIP] = trip_output_contact_o;
        state_word[F_CLOSE] = close_output_contact_o;
        state_word[F_LOCKOUT] = lockout_state_o;
        state_word[F_CYCLE] = reclose_cycle_state_o;
        state_word[F_BREAKER] = pin.breaker_status_input;
        state_word[F_ENABLE] = pin.reclose_enable_input;
        state_word[F_SHOT +: SHOT_W] = shot;
        state_word[F_PH_PU] = toc_pickup[0];
        state_word[F_RES_PU] = toc_pickup[1];
        state_word[F_PH_TOC] = toc_timed[0];
        state_word[F_RES_TOC] = toc_timed[1];
        state_word[F_MANUAL] = manual_close_local_bit;
    end

endmodule // rcc_reclose_ctrl

// ===== tb/rcc_breaker_model.sv
`timescale 1ns/100ps
module rcc_breaker_model #(
    parameter int unsigned DELAY = 20
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic trip_i,
    input wire logic close_i,
    output logic breaker_o
);
int cnt;
// Contacts move only after a command has been held for DELAY clocks.
// Trip wins over close, as in a trip-free mechanism.
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        breaker_o <= 1'b0;
        cnt <= 0;
    end else if ((trip_i && breaker_o) || (close_i && !trip_i && !breaker_o))
    begin
        cnt <= cnt + 1;
        if (cnt == DELAY) begin
            breaker_o <= !breaker_o;
            cnt <= 0;
        end
    end else begin
        cnt <= 0;
    end
end
endmodule // rcc_breaker_model

// ===== tb/rcc_reclose_ctrl_chk.sv
`timescale 1ns/100ps
module rcc_reclose_ctrl_chk import rcc_pkg::*; #(
    parameter int unsigned TICK_DIV = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire rcc_pins_t pins_i,
    input wire rcc_bus_t bus_i,
    input wire logic [DW-1:0] rdata_o,
    input wire logic trip_output_contact_o,
    input wire logic close_output_contact_o,
    input wire logic phase_toc_pickup_o,
    input wire logic residual_toc_pickup_o,
    input wire logic lockout_state_o,
    input wire logic reclose_cycle_state_o,
    input wire logic irq_o
);
default clocking cb @(posedge sys_clk_i); endclocking
default disable iff (rst_i);
int trip_n, off_n, brk_n, enl_n;
// Run lengths of trip high, trip low, breaker closed and enable low.
always_ff @(posedge sys_clk_i) begin
    trip_n <= trip_output_contact_o ? trip_n + 1 : 0;
    off_n <= trip_output_contact_o ? 0 : off_n + 1;
    brk_n <= pins_i.breaker_status_input ? brk_n + 1 : 0;
    enl_n <= pins_i.reclose_enable_input ? 0 : enl_n + 1;
end
sequence trip_ends;
    $fell(trip_output_contact_o);
endsequence
sequence auto_close;
    $rose(close_output_contact_o) && reclose_cycle_state_o;
endsequence
rst_outs_a: assert property (@(posedge sys_clk_i) disable iff (1'b0)
    rst_i |=> lockout_state_o && !trip_output_contact_o
    && !close_output_contact_o) else $error("outputs wrong after reset");
rdata_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == '0)
    else $error("read data outside read slot");
state_excl_a: assert property (
    !(lockout_state_o && reclose_cycle_state_o))
    else $error("lockout and cycle together");
trip_cycle_a: assert property ($rose(trip_output_contact_o)
    |-> reclose_cycle_state_o) else $error("trip without cycle state");
trip_min_a: assert property (trip_ends |-> trip_n >= 36 * TICK_DIV)
    else $error("trip shorter than minimum");
oi_stall_a: assert property (auto_close |-> off_n >= 120 * TICK_DIV)
    else $error("reclose before open interval");
close_rel_a: assert property (brk_n >= 3 * TICK_DIV + 4
    |-> !close_output_contact_o) else $error("close held with breaker closed");
lo_force_a: assert property (enl_n >= 3 * TICK_DIV + 4
    |-> lockout_state_o) else $error("no lockout with enable low");
endmodule // rcc_reclose_ctrl_chk
bind rcc_reclose_ctrl rcc_reclose_ctrl_chk #(.TICK_DIV(TICK_DIV))
    rcc_reclose_ctrl_chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .pins_i(pins_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .trip_output_contact_o(trip_output_contact_o),
    .close_output_contact_o(close_output_contact_o),
    .phase_toc_pickup_o(phase_toc_pickup_o),
    .residual_toc_pickup_o(residual_toc_pickup_o),
    .lockout_state_o(lockout_state_o),
    .reclose_cycle_state_o(reclose_cycle_state_o), .irq_o(irq_o));

// ===== tb/rcc_reclose_ctrl_bench.sv
`timescale 1ns/100ps
module rcc_reclose_ctrl_bench import rcc_pkg::*;;
localparam int unsigned TD = 4;
logic sys_clk_i = 1'b0;
logic rst_i = 1'b1;
logic en = 1'b0, inst = 1'b0, ph = 1'b0, res = 1'b0;
logic brk, trip, close, ph_pu, res_pu, lo, cy, irq;
rcc_bus_t bus = '0;
logic [DW-1:0] rdata;
int n_errors = 0, compares = 0, n;
wire [5:0] outs = {res_pu, ph_pu, cy, lo, close, trip};
////////////////////////////////////////////////////////////////////////
rcc_reclose_ctrl #(.TICK_DIV(TD)) rcc_reclose_ctrl_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pins_i({en, brk, inst, ph, res}),
    .bus_i(bus), .rdata_o(rdata), .trip_output_contact_o(trip),
    .close_output_contact_o(close), .phase_toc_pickup_o(ph_pu),
    .residual_toc_pickup_o(res_pu), .lockout_state_o(lo),
    .reclose_cycle_state_o(cy), .irq_o(irq));
rcc_breaker_model rcc_breaker_model_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .trip_i(trip), .close_i(close), .breaker_o(brk));
// Free-running 20 MHz clock.
initial forever #25 sys_clk_i = ~sys_clk_i;
////////////////////////////////////////////////////////////////////////
task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string w);
    compares++;
    if (got !== exp) begin
        n_errors++;
        $display("wrong value at %0t: %s got %h", $time, w, got);
    end
endtask
task chk_b(input logic got, input logic exp, input string w);
    compares++;
    if (got !== exp) begin
        n_errors++;
        $display("wrong value at %0t: %s got %b", $time, w, got);
    end
endtask
task chk_n(input int got, input int lo_b, input int hi_b, input string w);
    compares++;
    if (got < lo_b || got > hi_b) begin
        n_errors++;
        $display("wrong value at %0t: %s took %0d", $time, w, got);
    end
endtask
task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk_i);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_i);
    bus <= '0;
endtask
task rd(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string w);
    @(posedge sys_clk_i);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk_i);
    bus <= '0;
    #1 chk(rdata, exp, w);
endtask
// Counts clocks until an output reaches a level; bounded so a hang shows.
task await(input int k, input logic v, output int cnt);
    cnt = 0;
    while (outs[k] !== v && cnt < 20000) begin
        @(posedge sys_clk_i);
        #1 cnt++;
    end
    if (cnt >= 20000) chk_n(cnt, 0, 19999, "wait");
endtask
////////////////////////////////////////////////////////////////////////
task t_reset;
    rd(REG_STATE, 16'h0004, "state");
    rd(REG_LO_RESET, LO_RESET_RST, "lo reset");
    rd(REG_MIN_TRIP, MIN_TRIP_RST, "min trip");
    rd(REG_OPEN_INT1, OPEN_INT1_RST, "open int");
    $display("test reset done");
endtask
task t_close;
    @(posedge sys_clk_i);
    en <= 1'b1;
    wr(REG_IRQ_MASK, 16'h0008);
    wr(REG_CTRL, 16'h0001);
    await(1, 1'b1, n);
    chk_n(n, 0, 2 * TD + 2, "manual close");
    repeat (TD + 2) @(posedge sys_clk_i);
    #1 chk_b(close, 1'b1, "close latched");
    rd(REG_CTRL, 16'h0000, "local bit");
    await(1, 1'b0, n);
    await(2, 1'b0, n);
    chk_n(n, 1200 * TD - 8, 1200 * TD + 4, "lockout exit");
    chk_b(irq, 1'b1, "irq set");
    wr(REG_IRQ_STAT, 16'h001f);
    repeat (2) @(posedge sys_clk_i);
    #1 chk_b(irq, 1'b0, "irq cleared");
    $display("test close done");
endtask
task t_fault;
    @(posedge sys_clk_i);
    ph <= 1'b1;
    res <= 1'b1;
    await(4, 1'b1, n);
    chk_b(res_pu, 1'b1, "pickups together");
    @(posedge sys_clk_i);
    inst <= 1'b1;
    await(0, 1'b1, n);
    chk_b(cy, 1'b1, "cycle state");
    @(posedge sys_clk_i);
    {inst, ph, res} <= 3'h0;
    await(0, 1'b0, n);
    chk_n(n, 36 * TD - 1, 36 * TD + 1, "trip length");
    chk_b(ph_pu, 1'b0, "pickup drop");
    await(1, 1'b1, n);
    chk_n(n, 120 * TD - 1, 120 * TD + 1, "open interval");
    await(3, 1'b0, n);
    chk_b(lo, 1'b0, "back to reset");
    $display("test fault done");
endtask
task t_lockout;
    @(posedge sys_clk_i);
    en <= 1'b0;
    await(2, 1'b1, n);
    chk_n(n, 0, 3 * TD + 4, "forced lockout");
    wr(REG_CTRL, 16'h0001);
    repeat (3 * TD) @(posedge sys_clk_i);
    #1 chk_b(close, 1'b0, "close refused");
    $display("test lockout done");
endtask
task summarize;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
// Main sequence; reset is held for ten clocks.
initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_close();
    t_fault();
    t_lockout();
    summarize();
end
// Watchdog sized well above the roughly 10400 clocks the tests need.
initial begin
    #(40000 * 50);
    n_errors++;
    summarize();
end
endmodule // rcc_reclose_ctrl_bench
